// ---- dv/host_serial_model.sv ----
// Host controller model that programs the core over the three-wire link.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  input  wire logic clk,               // System clock.
  output logic      serial_clk,        // Serial clock, low outside words.
  output logic      serial_data,       // Serial data.
  output logic      latch_load_strobe  // Load strobe.
);
  // ********
  // Link driver
  // ********
  // Idle link at time zero.
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_load_strobe = 1'b0;
  end
  // Three clocks per phase keeps both synchroniser margins on the device side.
  task automatic send_word(input logic [23:0] w, input int nbits);
    // Callers may return on a falling edge; pins only ever move just after a rising one.
    @(posedge clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data <= w[i];
      repeat (3) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clk);
      serial_clk <= 1'b0;
    end
    // A released data line shows the inverse so a stale bit is never mistaken.
    serial_data <= ~w[0];
    repeat (3) @(posedge clk);
    latch_load_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    latch_load_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : send_word
endmodule : host_serial_model
`default_nettype wire

// ---- dv/pll_core_assertions.sv ----
// Port-level concurrent checks for the synthesizer core.
`timescale 1ns/1ps
`default_nettype none
module pll_core_assertions (
  input wire logic clk,                // Clock.
  input wire logic arst_n,             // Reset, active low.
  input wire logic serial_clk,         // Serial clock.
  input wire logic serial_data,        // Serial data.
  input wire logic latch_load_strobe,  // Load strobe.
  input wire logic chip_enable,        // Enable pin.
  input wire logic reference_input,    // Reference pin.
  input wire logic rf_feedback_input,  // RF pin.
  input wire logic charge_pump_up,     // Lead pulse.
  input wire logic charge_pump_down,   // Lag pulse.
  input wire logic charge_pump_oe,     // Pump driven.
  input wire logic observe_output_pin, // Mux value.
  input wire logic observe_output_oe,  // Mux driven.
  input wire logic lock_detect,        // Digital lock.
  input wire logic powered_down        // Power-down.
);
  // ********
  // Checks
  // ********
  logic [3:0] quiet_reg;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since the pump moved or the part slept; a lock loss needs a recent cause.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) quiet_reg <= 4'hf;
    else if (charge_pump_up || charge_pump_down || powered_down) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
  end
  a_ce_powers_down: assert property ($fell(chip_enable) |-> ##[1:5] powered_down)
    else $error("no power-down after enable fell");
  a_ce_floats_pump: assert property ((!chip_enable)[*6] |-> !charge_pump_oe)
    else $error("pump driven with enable low");
  a_pd_floats_pump: assert property (powered_down[*2] |-> !charge_pump_oe)
    else $error("pump driven in power-down");
  a_pd_clears_lock: assert property (powered_down[*3] |-> !lock_detect)
    else $error("lock held in power-down");
  a_abw_bounded: assert property ($rose(charge_pump_up && charge_pump_down)
    |-> ##[1:4] !(charge_pump_up && charge_pump_down))
    else $error("reset pulse too long");
  a_lock_fall_cause: assert property ($fell(lock_detect)
    |-> (quiet_reg < 4'h6) or (##[0:2] powered_down))
    else $error("lock lost without phase error");
  a_lock_rise_awake: assert property ($rose(lock_detect)
    |-> !powered_down && !$past(powered_down, 4))
    else $error("lock set while asleep");
  a_pump_no_swap: assert property (charge_pump_up && !charge_pump_down
    |=> charge_pump_up || !charge_pump_down)
    else $error("lead turned to lag directly");
endmodule : pll_core_assertions
bind pll_core pll_core_assertions pll_core_assertions_inst (
  .clk(clk), .arst_n(arst_n), .serial_clk(serial_clk), .serial_data(serial_data),
  .latch_load_strobe(latch_load_strobe), .chip_enable(chip_enable),
  .reference_input(reference_input), .rf_feedback_input(rf_feedback_input),
  .charge_pump_up(charge_pump_up), .charge_pump_down(charge_pump_down),
  .charge_pump_oe(charge_pump_oe), .observe_output_pin(observe_output_pin),
  .observe_output_oe(observe_output_oe), .lock_detect(lock_detect), .powered_down(powered_down));
`default_nettype wire

// ---- dv/test_pll_core.sv ----
// Self-checking bench for the synthesizer digital core.
`timescale 1ns/1ps
`default_nettype none
module test_pll_core import pll_core_pkg::*;;
  // ********
  // Stimulus and checks
  // ********
  logic clk, arst_n, chip_enable;
  logic reference_input = 1'b0;
  logic rf_feedback_input = 1'b0;
  logic serial_clk, serial_data, latch_load_strobe;
  logic charge_pump_up, charge_pump_down, charge_pump_oe;
  logic observe_output_pin, observe_output_oe, lock_detect, powered_down;
  logic [3:0] ph = 4'h0;
  logic [7:0] hist = 8'h00;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int lag = 0;
  host_serial_model host_serial_model_inst (.clk(clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_load_strobe(latch_load_strobe));
  pll_core pll_core_inst (.clk(clk), .arst_n(arst_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_load_strobe(latch_load_strobe), .chip_enable(chip_enable),
    .reference_input(reference_input), .rf_feedback_input(rf_feedback_input),
    .charge_pump_up(charge_pump_up), .charge_pump_down(charge_pump_down),
    .charge_pump_oe(charge_pump_oe), .observe_output_pin(observe_output_pin),
    .observe_output_oe(observe_output_oe), .lock_detect(lock_detect), .powered_down(powered_down));
  // 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Both inputs come from one phase counter, so their skew is exact in clocks.
  always @(posedge clk) begin
    ph <= ph + 4'h1;
    hist <= {hist[6:0], ph < 4'h8};
    reference_input <= hist[0];
    rf_feedback_input <= hist[lag];
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  function automatic logic [23:0] ref_word(logic [13:0] r, logic [1:0] abw, logic lks);
    return (24'(r) << REF_LSB) | (24'(abw) << ABW_LSB) | (24'(lks) << LKSEL_BIT) | 24'(SEL_REF);
  endfunction : ref_word
  function automatic logic [23:0] func_word(logic [2:0] os, logic clr, logic slp, logic off, logic [1:0] s);
    return (24'(os) << OSEL_LSB) | (24'(clr) << CLR_BIT) | (24'(slp) << SLEEP_BIT) | (24'(off) << CPTRI_BIT) | 24'(s);
  endfunction : func_word
  task automatic send(input logic [23:0] w);
    host_serial_model_inst.send_word(w, 24);
  endtask : send
  // Lag changes only while both inputs are low, so no half-formed edge pair appears.
  task automatic lag_to(input int v);
    while (ph != 4'hf) @(posedge clk);
    lag <= v;
  endtask : lag_to
  task automatic rises(input int n, output int r);
    logic prev;
    r = 0;
    @(negedge clk);
    prev = observe_output_pin;
    repeat (n) begin
      @(negedge clk);
      if (observe_output_pin === 1'b1 && prev !== 1'b1) r++;
      prev = observe_output_pin;
    end
  endtask : rises
  task automatic edges_to_lock(output int k);
    int t;
    logic prev;
    k = 0;
    t = 0;
    prev = reference_input;
    while (lock_detect !== 1'b1 && t < 800) begin
      @(negedge clk);
      if (reference_input && !prev) k++;
      prev = reference_input;
      t++;
    end
  endtask : edges_to_lock
  task automatic t_power();
    repeat (10) @(posedge clk);
    chk("powered_down", 0, powered_down);
    chk("charge_pump_oe", 1, charge_pump_oe);
    chip_enable <= 1'b0;
    repeat (8) @(posedge clk);
    chk("powered_down", 1, powered_down);
    chk("charge_pump_oe", 0, charge_pump_oe);
    chip_enable <= 1'b1;
    send(func_word(OSEL_RST, 1'b0, 1'b1, 1'b0, SEL_FUNC));
    chk("powered_down", 1, powered_down);
    send(func_word(OSEL_RST, 1'b0, 1'b0, 1'b1, SEL_FUNC));
    chk("powered_down", 0, powered_down);
    chk("charge_pump_oe", 0, charge_pump_oe);
    $display("t_power done");
  endtask : t_power
  task automatic t_divide();
    int n;
    send(ref_word(14'h3, 2'h2, 1'b0));
    send(24'(13'h5) << FB_LSB | 24'(SEL_FB));
    send(func_word(OSEL_REFDIV, 1'b0, 1'b0, 1'b0, SEL_FUNC));
    rises(480, n);
    chk("reference pulses", 10, n);
    host_serial_model_inst.send_word(func_word(OSEL_FBDIV, 1'b0, 1'b0, 1'b0, SEL_FUNC), 8);
    rises(480, n);
    chk("feedback pulses", 6, n);
    send(func_word(OSEL_REFDIV, 1'b1, 1'b0, 1'b0, SEL_FUNC));
    rises(200, n);
    chk("pulses in clear", 0, n);
    send(func_word(OSEL_RST, 1'b0, 1'b0, 1'b0, SEL_FUNC));
    chk("observe_output_pin", 0, observe_output_pin);
    chk("observe_output_oe", 1, observe_output_oe);
    send(func_word(OSEL_REFDIV, 1'b0, 1'b0, 1'b0, SEL_INIT));
    rises(480, n);
    chk("pulses after init", 10, n);
    $display("t_divide done");
  endtask : t_divide
  task automatic t_lock();
    int k;
    int t;
    int n;
    logic prev;
    send(ref_word(14'h1, 2'h2, 1'b0));
    send(24'(13'h1) << FB_LSB | 24'(SEL_FB));
    send(func_word(OSEL_DLD, 1'b0, 1'b0, 1'b0, SEL_FUNC));
    lag_to(4);
    k = 0;
    t = 0;
    while (!(charge_pump_up === 1'b1 && charge_pump_down === 1'b1) && t < 100) begin
      @(negedge clk);
      t++;
    end
    while (charge_pump_up === 1'b1 && charge_pump_down === 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("both-high width", 3, k);
    lag_to(0);
    edges_to_lock(k);
    chk("short lock count", 1, k == 3 || k == 4);
    // The multiplexer copy of the lock flag trails it by one clock.
    @(negedge clk);
    chk("observe_output_pin", 1, observe_output_pin);
    lag_to(1);
    repeat (128) @(posedge clk);
    chk("lock held", 1, lock_detect);
    lag_to(4);
    repeat (64) @(posedge clk);
    chk("lock cleared", 0, lock_detect);
    send(ref_word(14'h1, 2'h2, 1'b1));
    lag_to(0);
    edges_to_lock(k);
    chk("long lock count", 1, k == 5 || k == 6);
    // Locked with no skew, the pin is pulled low once per comparison cycle.
    send(func_word(OSEL_ALD, 1'b0, 1'b0, 1'b0, SEL_FUNC));
    n = 0;
    @(negedge clk);
    prev = observe_output_oe;
    repeat (160) begin
      @(negedge clk);
      if (observe_output_oe === 1'b1 && prev !== 1'b1) n++;
      prev = observe_output_oe;
    end
    chk("pull-low pulses", 10, n);
    chk("observe_output_pin", 0, observe_output_pin);
    chk("lock under pull-low", 1, lock_detect);
    @(posedge clk);
    chip_enable <= 1'b0;
    repeat (8) @(posedge clk);
    chk("lock in power-down", 0, lock_detect);
    chip_enable <= 1'b1;
    $display("t_lock done");
  endtask : t_lock
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    chip_enable = 1'b1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_power();
    t_divide();
    t_lock();
    results();
  end
endmodule : test_pll_core
`default_nettype wire

// ---- verilog/pll_core.sv ----
// Digital core: serial loading, latches, dividers, phase comparator and lock detect.
`default_nettype none
`timescale 1ns/1ps
module pll_core
  import pll_core_pkg::*;
(
  input  wire logic clk,                // System clock, 50 MHz.
  input  wire logic arst_n,             // Asynchronous reset, active low.
  input  wire logic serial_clk,         // Serial programming clock pin.
  input  wire logic serial_data,        // Serial programming data pin.
  input  wire logic latch_load_strobe,  // Load strobe pin.
  input  wire logic chip_enable,        // Chip enable pin, high runs.
  input  wire logic reference_input,    // Reference frequency pin.
  input  wire logic rf_feedback_input,  // RF feedback pin.
  output logic      charge_pump_up,     // Comparator lead pulse.
  output logic      charge_pump_down,   // Comparator lag pulse.
  output logic      charge_pump_oe,     // Charge pump driven when high.
  output logic      observe_output_pin, // Multiplexer output value.
  output logic      observe_output_oe,  // Multiplexer output driven when high.
  output logic      lock_detect,        // Digital lock indication.
  output logic      powered_down        // Device in power-down.
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NIN = 6;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] meta_reg;
  logic [NIN-1:0] sync_reg;
  logic [NIN-1:0] prev_reg;
  logic [NIN-1:0] rise;

  assign pin_raw = {rf_feedback_input, reference_input, chip_enable,
                    latch_load_strobe, serial_data, serial_clk};

  // Three flops per pin; logic reads the second and third, never the first.
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pin_raw[gi];
          sync_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= sync_reg[gi];
        end
      end
      assign rise[gi] = sync_reg[gi] & ~prev_reg[gi];
    end
  endgenerate

  logic sclk_rise;
  logic data_s;
  logic load_rise;
  logic ce_s;
  logic ref_tick;
  logic rf_tick;
  assign sclk_rise = rise[0];
  assign data_s    = sync_reg[1];
  assign load_rise = rise[2];
  assign ce_s      = sync_reg[3];
  assign ref_tick  = rise[4];
  assign rf_tick   = rise[5];

  // Latch select decode, used for every latch.
  function automatic logic sel_is(input logic [WORD_W-1:0] w, input logic [1:0] s);
    sel_is = (w[SEL_LSB +: 2] == s);
  endfunction : sel_is

  // ************************************************************
  // Shift register and latches
  // ************************************************************
  logic [WORD_W-1:0] shift_reg;

  // Data and clock share the same synchroniser depth, so setup stays aligned.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], data_s}; // see R1 R2
    end
  end

  logic [REF_W-1:0] ref_ratio_reg;
  logic [1:0]       abw_reg;
  logic             lksel_reg;
  logic [FB_W-1:0]  fb_ratio_reg;
  logic             clr_reg;
  logic             sleep_reg;
  logic [2:0]       osel_reg;
  logic             cptri_reg;
  logic             init_pulse_reg;

  // A short word is latched as it stands; nothing counts the edges.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_ratio_reg <= REF_RST;
      abw_reg       <= ABW_RST;
      lksel_reg     <= 1'b0;
      fb_ratio_reg  <= FB_RST;
    end else if (load_rise) begin // see R3 R17
      if (sel_is(shift_reg, SEL_REF)) begin // see R4
        ref_ratio_reg <= shift_reg[REF_LSB +: REF_W]; // see R6
        abw_reg       <= shift_reg[ABW_LSB +: 2]; // see R8
        lksel_reg     <= shift_reg[LKSEL_BIT];
      end
      if (sel_is(shift_reg, SEL_FB)) begin // see R4
        fb_ratio_reg <= shift_reg[FB_LSB +: FB_W]; // see R5
      end
    end
  end

  // Function and initialization latches share one layout.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_reg        <= 1'b0;
      sleep_reg      <= 1'b0;
      osel_reg       <= OSEL_RST;
      cptri_reg      <= 1'b0;
      init_pulse_reg <= 1'b0;
    end else begin
      init_pulse_reg <= load_rise & sel_is(shift_reg, SEL_INIT);
      if (load_rise & (sel_is(shift_reg, SEL_FUNC) | sel_is(shift_reg, SEL_INIT))) begin // see R4
        clr_reg   <= shift_reg[CLR_BIT];
        sleep_reg <= shift_reg[SLEEP_BIT];
        osel_reg  <= shift_reg[OSEL_LSB +: 3];
        cptri_reg <= shift_reg[CPTRI_BIT];
      end
    end
  end

  // ************************************************************
  // Power-down and dividers
  // ************************************************************
  logic pd_now;
  logic div_hold;
  assign pd_now   = ~ce_s | sleep_reg; // see R13
  assign div_hold = pd_now | clr_reg | init_pulse_reg; // see R15

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_down <= 1'b1;
    end else begin
      powered_down <= pd_now;
    end
  end

  logic ref_pulse;
  logic fb_pulse;

  pll_divider #(.W(REF_W)) u_ref_div (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (ref_tick),
    .hold   (div_hold),
    .ratio  (ref_ratio_reg),
    .pulse  (ref_pulse)
  );

  pll_divider #(.W(FB_W)) u_fb_div (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (rf_tick),
    .hold   (div_hold),
    .ratio  (fb_ratio_reg),
    .pulse  (fb_pulse)
  );

  // ************************************************************
  // Phase comparator with antibacklash overlap
  // ************************************************************
  cmp_state_e cmp_reg;
  logic [1:0] abw_cnt_reg;
  logic [7:0] err_cnt_reg;
  logic       err_done_reg;

  // The overlap in the reset state lasts width+1 cycles; zero width is the narrowest.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_reg      <= CMP_IDLE;
      abw_cnt_reg  <= 2'h0;
      err_cnt_reg  <= 8'h00;
      err_done_reg <= 1'b0;
    end else if (div_hold) begin
      cmp_reg      <= CMP_IDLE;
      abw_cnt_reg  <= 2'h0;
      err_cnt_reg  <= 8'h00;
      err_done_reg <= 1'b0;
    end else begin
      err_done_reg <= 1'b0;
      case (cmp_reg)
        CMP_IDLE: begin
          err_cnt_reg <= 8'h00;
          abw_cnt_reg <= abw_reg;
          if (ref_pulse & fb_pulse) begin
            cmp_reg      <= CMP_RST; // see R7
            err_done_reg <= 1'b1;
          end else if (ref_pulse) begin
            cmp_reg <= CMP_UP;
          end else if (fb_pulse) begin
            cmp_reg <= CMP_DN;
          end
        end
        CMP_UP, CMP_DN: begin
          if ((cmp_reg == CMP_UP && fb_pulse) || (cmp_reg == CMP_DN && ref_pulse)) begin
            cmp_reg      <= CMP_RST; // see R7
            err_done_reg <= 1'b1;
          end
          if (err_cnt_reg != 8'hff) begin
            err_cnt_reg <= err_cnt_reg + 8'h01;
          end
        end
        CMP_RST: begin
          if (abw_cnt_reg == 2'h0) begin
            cmp_reg <= CMP_IDLE; // see R8
          end else begin
            abw_cnt_reg <= abw_cnt_reg - 2'h1;
          end
        end
        default: cmp_reg <= CMP_IDLE;
      endcase
    end
  end

  // Charge pump pulses, floated in power-down or by the three-state bit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_pump_up   <= 1'b0;
      charge_pump_down <= 1'b0;
      charge_pump_oe   <= 1'b0;
    end else begin
      charge_pump_up   <= (cmp_reg == CMP_UP) | (cmp_reg == CMP_RST); // see R7
      charge_pump_down <= (cmp_reg == CMP_DN) | (cmp_reg == CMP_RST);
      charge_pump_oe   <= ~pd_now & ~cptri_reg; // see R13
    end
  end

  // ************************************************************
  // Digital lock detect
  // ************************************************************
  logic [2:0] good_cnt_reg;
  logic [2:0] need_cnt;
  assign need_cnt = lksel_reg ? LOCK_N_LONG : LOCK_N_SHORT; // see R9 R10

  // Errors between the two limits keep the lock state but break the run.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      good_cnt_reg <= 3'h0;
      lock_detect  <= 1'b0;
    end else if (pd_now) begin
      good_cnt_reg <= 3'h0;
      lock_detect  <= 1'b0;
    end else if (err_done_reg) begin
      if (err_cnt_reg < LOCK_CYC) begin
        if (good_cnt_reg + 3'h1 >= need_cnt) begin
          lock_detect <= 1'b1; // see R9 R10
        end
        if (good_cnt_reg != 3'h7) begin
          good_cnt_reg <= good_cnt_reg + 3'h1;
        end
      end else begin
        good_cnt_reg <= 3'h0;
        if (err_cnt_reg > UNLK_CYC) begin
          lock_detect <= 1'b0; // see R11
        end
      end
    end
  end

  // ************************************************************
  // Output multiplexer
  // ************************************************************
  // Divider pulses are one cycle wide; an observer sees their rate, not duty.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      observe_output_pin <= 1'b0;
      observe_output_oe  <= 1'b1;
    end else begin
      observe_output_oe <= 1'b1;
      case (osel_reg)
        OSEL_DLD:    observe_output_pin <= lock_detect; // see R12
        OSEL_FBDIV:  observe_output_pin <= fb_pulse; // see R12
        OSEL_REFDIV: observe_output_pin <= ref_pulse; // see R12
        OSEL_ALD: begin
          observe_output_pin <= 1'b0; // see R14
          observe_output_oe  <= (cmp_reg != CMP_IDLE);
        end
        default:     observe_output_pin <= 1'b0;
      endcase
    end
  end
endmodule : pll_core
`default_nettype wire

// ---- verilog/pll_core_pkg.sv ----
// Constants, field positions and state encodings for the synthesizer digital core.
// Function
// R1: Each rising serial clock edge shifts one data bit into the 24-bit shift register.
// R2: Host sends words MSB first, so the select bits arrive last.
// R3: A rising load strobe copies the shift register into exactly one latch.
// R4: The two lowest bits pick reference, feedback, function or initialization latch.
// R5: Feedback divider is a 13-bit counter dividing the RF input by 1 to 8191.
// R6: Reference divider is a 14-bit counter dividing the reference by 1 to 16383.
// R7: The phase comparator reports the difference between both divider outputs.
// R8: Two bits set antibacklash width; host should avoid the smallest width.
// R9: Lock count select 0 needs three consecutive cycles under 15 ns for lock.
// R10: Lock count select 1 needs five consecutive cycles under 15 ns for lock.
// R11: Lock stays high until a cycle shows phase error above 25 ns.
// R12: Output select field routes lock, divided RF or divided reference to the pin.
// R13: Low chip enable powers down and floats the charge pump; high obeys sleep bit.
// R14: Analog lock detect: open-drain pin high while locked, low pulses otherwise; the code also pulls it low once per comparison cycle while locked.
// R15: Counter clear bit holds both dividers in reset; clearing resumes aligned counting.
// R16: Each divider pulses once per division cycle, then reloads its ratio.
// R17: A short word is still latched as is when the load strobe rises.
`default_nettype none
package pll_core_pkg;
  // ************************************************************
  // Widths and latch selection
  // ************************************************************
  localparam int          WORD_W      = 24;
  localparam int          REF_W       = 14;
  localparam int          FB_W        = 13;
  localparam logic [1:0]  SEL_REF     = 2'h0;
  localparam logic [1:0]  SEL_FB      = 2'h1;
  localparam logic [1:0]  SEL_FUNC    = 2'h2;
  localparam logic [1:0]  SEL_INIT    = 2'h3;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          SEL_LSB     = 0;
  localparam int          REF_LSB     = 2;
  localparam int          ABW_LSB     = 16;
  localparam int          LKSEL_BIT   = 20;
  localparam int          FB_LSB      = 8;
  localparam int          CLR_BIT     = 2;
  localparam int          SLEEP_BIT   = 3;
  localparam int          OSEL_LSB    = 4;
  localparam int          CPTRI_BIT   = 8;
  // ************************************************************
  // Reset values and output select codes
  // ************************************************************
  localparam logic [REF_W-1:0] REF_RST  = 14'h0001;
  localparam logic [FB_W-1:0]  FB_RST   = 13'h0001;
  localparam logic [1:0]  ABW_RST     = 2'h0;
  localparam logic [2:0]  OSEL_RST    = 3'h0;
  localparam logic [2:0]  OSEL_DLD    = 3'h1;
  localparam logic [2:0]  OSEL_FBDIV  = 3'h2;
  localparam logic [2:0]  OSEL_REFDIV = 3'h3;
  localparam logic [2:0]  OSEL_ALD    = 3'h4;
  // ************************************************************
  // Timing, in picoseconds and in cycles of the 50 MHz clock
  // ************************************************************
  localparam int          CLK_PS      = 20000;
  localparam int          LOCK_ERR_PS = 15000;
  localparam int          UNLK_ERR_PS = 25000;
  localparam int          LOCK_CYC_I  = (LOCK_ERR_PS / CLK_PS) < 1 ? 1 : (LOCK_ERR_PS / CLK_PS);
  localparam int          UNLK_CYC_I  = (UNLK_ERR_PS / CLK_PS) < 1 ? 1 : (UNLK_ERR_PS / CLK_PS);
  localparam logic [7:0]  LOCK_CYC    = 8'(LOCK_CYC_I);
  localparam logic [7:0]  UNLK_CYC    = 8'(UNLK_CYC_I);
  localparam logic [2:0]  LOCK_N_SHORT = 3'h3;
  localparam logic [2:0]  LOCK_N_LONG  = 3'h5;
  // ************************************************************
  // Phase comparator states, Gray along idle-lead-reset
  // ************************************************************
  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00,
    CMP_UP   = 2'b01,
    CMP_RST  = 2'b11,
    CMP_DN   = 2'b10
  } cmp_state_e;
endpackage : pll_core_pkg
`default_nettype wire

// ---- verilog/pll_divider.sv ----
// Programmable divider that pulses once per division cycle of its input edges.
`default_nettype none
`timescale 1ns/1ps
module pll_divider #(
  parameter int W = 14
) (
  input  wire logic         clk,    // System clock.
  input  wire logic         arst_n, // Asynchronous reset, active low.
  input  wire logic         tick,   // One input edge, one cycle.
  input  wire logic         hold,   // Hold at load point.
  input  wire logic [W-1:0] ratio,  // Division ratio, zero acts as one.
  output logic              pulse   // One-cycle pulse per division cycle.
);
  logic [W-1:0] count_reg;

  // ************************************************************
  // Count down, pulse and reload
  // ************************************************************
  // Holding at the load point means both dividers restart together on release.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      pulse     <= 1'b0;
    end else if (hold) begin
      count_reg <= ratio; // see R15
      pulse     <= 1'b0;
    end else if (tick) begin
      if (count_reg <= W'(1)) begin
        count_reg <= ratio; // see R16
        pulse     <= 1'b1;
      end else begin
        count_reg <= count_reg - W'(1);
        pulse     <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule : pll_divider
`default_nettype wire
